// ==== hdl/acd_defs.vh ====
/*
  constants for the adc spi command decoder: command words, fixed
  responses, register addresses, reset values, field positions, crc.
  assumes it is included by bare name from the design files.
*/
`ifndef ACD_DEFS_VH
`define ACD_DEFS_VH

// command words
`define ACD_CMD_NULL        16'h0000
`define ACD_CMD_RESET       16'h0011
`define ACD_CMD_STANDBY     16'h0022
`define ACD_CMD_RESUME      16'h0033
`define ACD_CMD_LOCK        16'h0555
`define ACD_CMD_UNLOCK_A    16'h0655
`define ACD_CMD_UNLOCK_B    16'h0666

// fixed responses
`define ACD_RSP_RESET_OK    16'hFF54
`define ACD_RSP_RESET_CUT   16'h0011

// opcode patterns in bits 15:13
`define ACD_OP_READ         3'h5
`define ACD_OP_WRITE        3'h3
`define ACD_OP_READ_ACK     3'h7
`define ACD_OP_WRITE_ACK    3'h2

// clip codes
`define ACD_CODE_POS_MAX    16'h7FFF
`define ACD_CODE_NEG_MAX    16'h8000

// register addresses
`define ACD_ADDR_ID         8'h00
`define ACD_ADDR_STATUS     8'h01
`define ACD_ADDR_MODE       8'h02
`define ACD_ADDR_CLOCK      8'h03
`define ACD_ADDR_GAIN       8'h04
`define ACD_ADDR_GCHOP      8'h06
`define ACD_ADDR_CH0        8'h09
`define ACD_ADDR_RSV0       8'h0C
`define ACD_ADDR_CH1        8'h0E
`define ACD_ADDR_RSV1       8'h11
`define ACD_ADDR_CH2        8'h13
`define ACD_ADDR_CH3        8'h18
`define ACD_ADDR_LIMIT      8'h40

// reset values
`define ACD_RST_MODE        16'h0510
`define ACD_RST_CLOCK       16'h0F8E
`define ACD_RST_GCHOP       16'h0600
`define ACD_RST_RSV         16'h8000
`define ACD_RST_ZERO        16'h0000

// mode register fields
`define ACD_MODE_RXCRC      12
`define ACD_MODE_CRCTYPE    11
`define ACD_MODE_WLEN_HI    9
`define ACD_MODE_WLEN_LO    8

// crc
`define ACD_POLY_CCITT      16'h1021
`define ACD_POLY_ANSI       16'h8005
`define ACD_CRC_SEED        16'hFFFF

// frame shape
`define ACD_FRAME_WORDS     8'h06
`define ACD_LAST_BIT_16     5'h0F
`define ACD_LAST_BIT_24     5'h17
`define ACD_LAST_BIT_32     5'h1F

`endif

// ==== hdl/acd_sync3.v ====
/*
  three-stage synchroniser for one pin level.
  assumes the input is asynchronous to clock; output moves only when
  the second and third stages agree.
*/
module acd_sync3 #(
    parameter INIT = 1'b0
) (
    // clock and reset
    input  wire clock,
    input  wire nrst,
    // pin side
    input  wire pinIn,
    // clock side
    output wire levelOut
);

    reg s1_ff;     // first stage, read by s2 only
    reg s2_ff;     // second stage
    reg s3_ff;     // third stage
    reg level_ff;  // accepted level

    // chain plus agreement filter
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_ff    <= INIT;
            s2_ff    <= INIT;
            s3_ff    <= INIT;
            level_ff <= INIT;
        end
        else
        begin
            s1_ff <= pinIn;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // a change counts only once two stages agree
            if (s2_ff == s3_ff)
                level_ff <= s3_ff;
        end
    end

    assign levelOut = level_ff;

endmodule // acd_sync3

// ==== hdl/acd_spi_decoder.v ====
/*
  spi command decoder of a four-channel adc: frame framing, command
  execution, register file, responses, sample clipping and output crc.
  assumes a host in spi mode 1 (device shifts on sclk rise, host and
  device sample on sclk fall) and sclk slow enough for 3-ff sampling.
*/
`include "acd_defs.vh"

module acd_spi_decoder #(
    parameter         RAW_W    = 20,
    parameter [15:0]  ID_VALUE = 16'h5A04  // arbitrary identity value
) (
    // clock and reset
    input  wire             clock,
    input  wire             nrst,
    // spi pins
    input  wire             csN,
    input  wire             sclk,
    input  wire             din,
    output wire             dout,
    output wire             doutOe,
    // modulator results, signed, one lsb per code
    input  wire [RAW_W-1:0] rawCh0,
    input  wire [RAW_W-1:0] rawCh1,
    input  wire [RAW_W-1:0] rawCh2,
    input  wire [RAW_W-1:0] rawCh3,
    input  wire             sampleStrobe,
    // device state
    output wire             dataReadyN,
    output wire             standbyMode,
    output wire             interfaceLocked
);

    // synchronised pins
    wire        csNS;
    wire        sclkS;
    wire        dinS;

    acd_sync3 #(.INIT(1'b1)) u_syncCs (
        .clock    (clock),
        .nrst     (nrst),
        .pinIn    (csN),
        .levelOut (csNS)
    );
    acd_sync3 #(.INIT(1'b0)) u_syncSclk (
        .clock    (clock),
        .nrst     (nrst),
        .pinIn    (sclk),
        .levelOut (sclkS)
    );
    acd_sync3 #(.INIT(1'b0)) u_syncDin (
        .clock    (clock),
        .nrst     (nrst),
        .pinIn    (din),
        .levelOut (dinS)
    );

    // state
    reg  [15:0] cfg_ff [0:63];  // register file
    reg  [15:0] samp_ff [0:3];  // latched clipped samples
    reg         csPrev_ff;      // edge detect on chip select
    reg         sclkPrev_ff;    // edge detect on sclk
    reg  [4:0]  bitCnt_ff;      // bit inside word
    reg  [4:0]  lastBit_ff;     // word length latched per frame
    reg  [7:0]  wordIdx_ff;     // words completed, saturates
    reg  [15:0] inSh_ff;        // top 16 bits of incoming word
    reg  [31:0] outSh_ff;       // outgoing word, msb first
    reg         dout_ff;        // pin data
    reg         doutOe_ff;      // pin enable
    reg  [15:0] crcIn_ff;       // running input crc
    reg  [15:0] crcOut_ff;      // running output crc
    reg  [15:0] poly_ff;        // polynomial latched per frame
    reg         rxCrcEn_ff;     // input crc enable latched per frame
    reg         crcOk_ff;       // input crc word matched
    reg  [15:0] cmd_ff;         // command word of this frame
    reg  [6:0]  wrCnt_ff;       // registers written this frame
    reg  [15:0] resp_ff;        // response for the next frame
    reg         respStatus_ff;  // next response is live status
    reg         multi_ff;       // next frame is a multi read
    reg  [5:0]  rdAddr_ff;      // multi read start
    reg  [6:0]  rdCnt_ff;       // multi read count minus one
    reg         standby_ff;     // low-power mode
    reg         locked_ff;      // interface lock
    reg         crcErr_ff;      // sticky input crc error
    reg  [3:0]  data_ready_n_ff;        // unread conversion per channel
    integer     i;

    // crc feedback step, msb first, no reflection
    function [15:0] crcStep;
        input [15:0] crc;
        input        bitIn;
        input [15:0] poly;
        begin
            crcStep = {crc[14:0], 1'b0} ^ ((crc[15] ^ bitIn) ? poly
                                                              : 16'h0000);
        end
    endfunction

    // saturate a wide signed value to 16-bit two's complement
    function [15:0] clip;
        input [RAW_W-1:0] v;
        begin
            if (!v[RAW_W-1] && (|v[RAW_W-2:15]))
                clip = `ACD_CODE_POS_MAX;
            else if (v[RAW_W-1] && !(&v[RAW_W-2:15]))
                clip = `ACD_CODE_NEG_MAX;
            else
                clip = v[15:0];
        end
    endfunction

    // writable configuration addresses
    function isWritable;
        input [7:0] a;
        begin
            isWritable = (a == `ACD_ADDR_MODE) || (a == `ACD_ADDR_CLOCK) ||
                         (a == `ACD_ADDR_GAIN) || (a == `ACD_ADDR_GCHOP) ||
                         (a == `ACD_ADDR_CH0)  || (a == `ACD_ADDR_CH1)  ||
                         (a == `ACD_ADDR_CH2)  || (a == `ACD_ADDR_CH3);
        end
    endfunction

    // default contents per address
    function [15:0] rstVal;
        input [7:0] a;
        begin
            if (a == `ACD_ADDR_MODE)
                rstVal = `ACD_RST_MODE;
            else if (a == `ACD_ADDR_CLOCK)
                rstVal = `ACD_RST_CLOCK;
            else if (a == `ACD_ADDR_GCHOP)
                rstVal = `ACD_RST_GCHOP;
            else if (a == `ACD_ADDR_RSV0 || a == `ACD_ADDR_RSV1)
                rstVal = `ACD_RST_RSV;
            else
                rstVal = `ACD_RST_ZERO;
        end
    endfunction

    // derived mode and status
    wire [15:0] mode = cfg_ff[2];
    wire [15:0] statusWord = {locked_ff, 2'b00, crcErr_ff,
                              mode[`ACD_MODE_CRCTYPE:`ACD_MODE_WLEN_LO],
                              4'h0, data_ready_n_ff};

    // register read, unimplemented and out of range read zero
    function [15:0] regRead;
        input [7:0] a;
        begin
            if (a >= `ACD_ADDR_LIMIT)
                regRead = `ACD_RST_ZERO;
            else if (a == `ACD_ADDR_ID)
                regRead = ID_VALUE;
            else if (a == `ACD_ADDR_STATUS)
                regRead = statusWord;
            else
                regRead = cfg_ff[a[5:0]];
        end
    endfunction

    // frame edges
    wire active     = ~csNS;
    wire frameStart = csPrev_ff & ~csNS;
    wire frameEnd   = ~csPrev_ff & csNS;
    wire sclkRise   = active & ~sclkPrev_ff & sclkS;
    wire sclkFall   = active & sclkPrev_ff & ~sclkS;
    wire wordDone   = sclkFall & (bitCnt_ff == lastBit_ff);

    // incoming word, padding bits beyond 16 are dropped
    wire [15:0] inWord = (lastBit_ff == `ACD_LAST_BIT_16) ?
                         {inSh_ff[14:0], dinS} : inSh_ff;
    wire [15:0] crcInNext = crcStep(crcIn_ff, dinS, poly_ff);

    // command classification
    wire        isRead   = cmd_ff[15:13] == `ACD_OP_READ;
    wire        isWrite  = cmd_ff[15:13] == `ACD_OP_WRITE;
    wire        isUnlock = (cmd_ff == `ACD_CMD_UNLOCK_A) ||
                           (cmd_ff == `ACD_CMD_UNLOCK_B);
    wire [7:0]  wrLast   = {1'b0, cmd_ff[6:0]} + 8'h01;
    wire [7:0]  inCrcIdx = isWrite ? wrLast + 8'h01 : 8'h01;
    wire        crcFail  = rxCrcEn_ff & ~crcOk_ff;
    wire        gotCmd   = wordIdx_ff != 8'h00;
    // locked: only no-op, read and unlock pass
    wire        okCmd    = ~crcFail & (~locked_ff | isUnlock | isRead |
                           (cmd_ff == `ACD_CMD_NULL));
    wire        execReset = frameEnd & gotCmd & okCmd &
                            (cmd_ff == `ACD_CMD_RESET) &
                            (wordIdx_ff >= `ACD_FRAME_WORDS);

    // write strobe for each data word as it completes
    wire [7:0]  wrAddr = {2'b00, cmd_ff[12:7]} + wordIdx_ff - 8'h01;
    wire        wrSlot = wordDone & isWrite & ~locked_ff &
                         (wordIdx_ff >= 8'h01) && (wordIdx_ff <= wrLast);
    wire        wrEn   = wrSlot & isWritable(wrAddr);

    // next outgoing word
    wire [7:0]  selIdx  = frameStart ? 8'h00 : wordIdx_ff + 8'h01;
    wire [7:0]  crcOIdx = multi_ff ? {1'b0, rdCnt_ff} + 8'h02
                                   : `ACD_FRAME_WORDS - 8'h01;
    wire [7:0]  rdSel   = {2'b00, rdAddr_ff} + selIdx - 8'h01;
    reg  [15:0] selWord;

    // output word mux by position in frame
    always @*
    begin
        if (selIdx == 8'h00)
        begin
            if (multi_ff)
                selWord = {`ACD_OP_READ_ACK, rdAddr_ff, rdCnt_ff};
            else if (respStatus_ff)
                selWord = statusWord;
            else
                selWord = resp_ff;
        end
        else if (selIdx == crcOIdx)
            selWord = crcOut_ff;
        else if (multi_ff && selIdx < crcOIdx)
            selWord = regRead(rdSel);
        else if (!multi_ff && selIdx < crcOIdx)
            selWord = samp_ff[selIdx[1:0] - 2'b01];
        else
            selWord = 16'h0000;
    end

    // register file: defaults, command reset, per-word writes
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            for (i = 0; i < 64; i = i + 1)
                cfg_ff[i] <= rstVal(i[7:0]);
        end
        else if (execReset)
        begin
            for (i = 0; i < 64; i = i + 1)
                cfg_ff[i] <= rstVal(i[7:0]);
        end
        else if (wrEn)
            cfg_ff[wrAddr[5:0]] <= inWord;
    end

    // sample latch and data-ready flags
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            for (i = 0; i < 4; i = i + 1)
                samp_ff[i] <= 16'h0000;
            data_ready_n_ff <= 4'h0;
        end
        else
        begin
            // flags drop once the fourth channel word leaves
            if (wordDone && !multi_ff && wordIdx_ff == 8'h04)
                data_ready_n_ff <= 4'h0;
            // a new conversion wins over the clear
            if (sampleStrobe && !standby_ff)
            begin
                samp_ff[0] <= clip(rawCh0);
                samp_ff[1] <= clip(rawCh1);
                samp_ff[2] <= clip(rawCh2);
                samp_ff[3] <= clip(rawCh3);
                data_ready_n_ff    <= 4'hF;
            end
        end
    end

    // serial framing, shifting and crc engines
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            csPrev_ff   <= 1'b1;
            sclkPrev_ff <= 1'b0;
            bitCnt_ff   <= 5'h00;
            lastBit_ff  <= `ACD_LAST_BIT_24;
            wordIdx_ff  <= 8'h00;
            inSh_ff     <= 16'h0000;
            outSh_ff    <= 32'h0000_0000;
            dout_ff     <= 1'b0;
            doutOe_ff   <= 1'b0;
            crcIn_ff    <= `ACD_CRC_SEED;
            crcOut_ff   <= `ACD_CRC_SEED;
            poly_ff     <= `ACD_POLY_CCITT;
            rxCrcEn_ff  <= 1'b0;
            crcOk_ff    <= 1'b0;
            cmd_ff      <= `ACD_CMD_NULL;
            wrCnt_ff    <= 7'h00;
        end
        else
        begin
            csPrev_ff   <= csNS;
            sclkPrev_ff <= sclkS;
            doutOe_ff   <= active;
            if (frameStart)
            begin
                // latch frame shape from mode, load the response word
                case (mode[`ACD_MODE_WLEN_HI:`ACD_MODE_WLEN_LO])
                    2'b00:   lastBit_ff <= `ACD_LAST_BIT_16;
                    2'b01:   lastBit_ff <= `ACD_LAST_BIT_24;
                    default: lastBit_ff <= `ACD_LAST_BIT_32;
                endcase
                poly_ff    <= mode[`ACD_MODE_CRCTYPE] ? `ACD_POLY_ANSI
                                                      : `ACD_POLY_CCITT;
                rxCrcEn_ff <= mode[`ACD_MODE_RXCRC];
                bitCnt_ff  <= 5'h00;
                wordIdx_ff <= 8'h00;
                crcIn_ff   <= `ACD_CRC_SEED;
                crcOut_ff  <= `ACD_CRC_SEED;
                crcOk_ff   <= 1'b0;
                cmd_ff     <= `ACD_CMD_NULL;
                wrCnt_ff   <= 7'h00;
                outSh_ff   <= {selWord, 16'h0000};
                dout_ff    <= 1'b0;
            end
            else if (sclkRise)
            begin
                // device drives the next bit on the rising edge
                dout_ff   <= outSh_ff[31];
                outSh_ff  <= {outSh_ff[30:0], 1'b0};
                crcOut_ff <= crcStep(crcOut_ff, outSh_ff[31], poly_ff);
            end
            else if (sclkFall)
            begin
                crcIn_ff <= crcInNext;
                if (bitCnt_ff < 5'h10)
                    inSh_ff <= {inSh_ff[14:0], dinS};
                if (wordDone)
                begin
                    bitCnt_ff <= 5'h00;
                    if (wordIdx_ff != 8'hFF)
                        wordIdx_ff <= wordIdx_ff + 8'h01;
                    if (wordIdx_ff == 8'h00)
                        cmd_ff <= inWord;
                    // residue of zero means the crc word matched
                    if (rxCrcEn_ff && wordIdx_ff == inCrcIdx)
                        crcOk_ff <= (crcInNext == 16'h0000);
                    if (wrEn)
                        wrCnt_ff <= wrCnt_ff + 7'h01;
                    outSh_ff <= {selWord, 16'h0000};
                end
                else
                    bitCnt_ff <= bitCnt_ff + 5'h01;
            end
            else if (!active)
                dout_ff <= 1'b0;
        end
    end

    // frame-end command execution and next response
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            resp_ff       <= `ACD_RST_ZERO;
            respStatus_ff <= 1'b1;
            multi_ff      <= 1'b0;
            rdAddr_ff     <= 6'h00;
            rdCnt_ff      <= 7'h00;
            standby_ff    <= 1'b0;
            locked_ff     <= 1'b0;
            crcErr_ff     <= 1'b0;
        end
        else
        begin
            // status word left the device: drop the error flag
            if (wordDone && wordIdx_ff == 8'h00 && respStatus_ff &&
                !multi_ff)
                crcErr_ff <= 1'b0;
            if (frameEnd)
            begin
                // defaults: no-op answer
                respStatus_ff <= 1'b1;
                multi_ff      <= 1'b0;
                if (gotCmd && crcFail)
                    crcErr_ff <= 1'b1;
                else if (gotCmd && okCmd)
                begin
                    if (cmd_ff == `ACD_CMD_RESET)
                    begin
                        respStatus_ff <= 1'b0;
                        if (execReset)
                        begin
                            resp_ff    <= `ACD_RSP_RESET_OK;
                            standby_ff <= 1'b0;
                            locked_ff  <= 1'b0;
                            crcErr_ff  <= 1'b0;
                        end
                        else
                            resp_ff <= `ACD_RSP_RESET_CUT;
                    end
                    else if (cmd_ff == `ACD_CMD_STANDBY)
                    begin
                        standby_ff    <= 1'b1;
                        resp_ff       <= cmd_ff;
                        respStatus_ff <= 1'b0;
                    end
                    else if (cmd_ff == `ACD_CMD_RESUME)
                    begin
                        standby_ff    <= 1'b0;
                        resp_ff       <= cmd_ff;
                        respStatus_ff <= 1'b0;
                    end
                    else if (cmd_ff == `ACD_CMD_LOCK)
                    begin
                        locked_ff     <= 1'b1;
                        resp_ff       <= cmd_ff;
                        respStatus_ff <= 1'b0;
                    end
                    else if (isUnlock)
                    begin
                        locked_ff     <= 1'b0;
                        resp_ff       <= cmd_ff;
                        respStatus_ff <= 1'b0;
                    end
                    else if (isRead && cmd_ff[6:0] == 7'h00)
                    begin
                        resp_ff <= regRead({2'b00, cmd_ff[12:7]});
                        respStatus_ff <= 1'b0;
                    end
                    else if (isRead)
                    begin
                        multi_ff      <= 1'b1;
                        rdAddr_ff     <= cmd_ff[12:7];
                        rdCnt_ff      <= cmd_ff[6:0];
                        respStatus_ff <= 1'b0;
                    end
                    else if (isWrite)
                    begin
                        resp_ff <= {`ACD_OP_WRITE_ACK, cmd_ff[12:7],
                                    wrCnt_ff - 7'h01};
                        respStatus_ff <= 1'b0;
                    end
                end
            end
        end
    end

    // pins and state outputs
    assign dout            = dout_ff;
    assign doutOe          = doutOe_ff;
    assign dataReadyN      = ~(|data_ready_n_ff);
    assign standbyMode     = standby_ff;
    assign interfaceLocked = locked_ff;

endmodule // acd_spi_decoder

// ==== test/acd_host.sv ====
/* spi host model, mode 1, 24-bit words (reset default width).
   assumes a 20 ns system clock to pace its pins. */
module acd_host (
    // pacing clock
    input  wire logic clock,
    // spi pins
    output logic      csN,
    output logic      sclk,
    output logic      din,
    input  wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] got [0:7];  // top 16 bits of each word received
    int          padHi = 0;  // padding bits seen high, all frames
    initial {csN, sclk, din} = 3'b100;
    // half period of 80 ns, just after a clock edge
    task automatic half();
        repeat (4) @(posedge clock);
        #1;
    endtask
    // command word, one data word, then zero words
    task automatic frame(input logic [15:0] c, d, input int nw);
        logic [23:0] w;
        half();
        csN = 0;
        // lead time, else the first sclk rise meets the frame start
        half();
        for (int k = 0; k < nw; k++)
        begin
            // write data follows the command at once
            w = k == 0 ? {c, 8'h00} : k == 1 ? {d, 8'h00} : 24'h00_0000;
            for (int b = 23; b >= 0; b--)
            begin
                sclk = 1;
                din = w[b];
                half();
                sclk = 0;
                half();
                // sample late in the low phase, dout lags the pin
                if (b > 7) got[k][b-8] = dout;
                else if (dout) padHi++;
            end
        end
        half();
        csN = 1;
        din = ~din;  // released line shows no stale level
        repeat (3) half();
    endtask
endmodule // acd_host

// ==== test/acd_spi_decoder_monitor.sv ====
/* pin-level checker for the spi decoder.
   assumes it is bound to acd_spi_decoder. */
module acd_spi_decoder_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // pins and state
    input wire logic csN,
    input wire logic dout,
    input wire logic doutOe,
    input wire logic sampleStrobe,
    input wire logic dataReadyN,
    input wire logic standbyMode,
    input wire logic interfaceLocked
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // six cycles covers the pin synchroniser delay
    sequence s_idle; csN [*6]; endsequence
    sequence s_busy; !csN [*6]; endsequence
    a_oe_idle_off: assert property (s_idle |-> !doutOe)
        else $error("oe high outside frame");
    a_oe_busy_on: assert property (s_busy |-> doutOe)
        else $error("oe low inside frame");
    a_dout_idle_low: assert property (s_idle |-> !dout)
        else $error("dout high outside frame");
    a_strobe_sets_ready: assert property (sampleStrobe && !standbyMode
        |=> !dataReadyN) else $error("no ready after strobe");
    a_standby_no_ready: assert property (sampleStrobe && standbyMode
        && dataReadyN |=> dataReadyN) else $error("strobe taken in standby");
    a_mode_frame_end: assert property ($changed(standbyMode)
        |-> csN && $past(csN, 3)) else $error("standby moved in frame");
    a_lock_frame_end: assert property ($changed(interfaceLocked)
        |-> csN && $past(csN, 3)) else $error("lock moved in frame");
    a_lock_holds_mode: assert property (interfaceLocked
        && $past(interfaceLocked) |-> $stable(standbyMode))
        else $error("mode changed while locked");
endmodule // acd_spi_decoder_monitor
bind acd_spi_decoder acd_spi_decoder_monitor i_acd_spi_decoder_monitor (
    .clock(clock), .nrst(nrst), .csN(csN), .dout(dout), .doutOe(doutOe),
    .sampleStrobe(sampleStrobe), .dataReadyN(dataReadyN),
    .standbyMode(standbyMode), .interfaceLocked(interfaceLocked));

// ==== test/adc_spi_command_decoder_tb.sv ====
/* self-checking bench of the spi decoder.
   assumes acd_host drives the spi pins. */
module adc_spi_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, nrst, csN, sclk, din, dout, sampleStrobe;
    logic [19:0] rawCh0, rawCh1, rawCh2, rawCh3;
    wire         dataReadyN, standbyMode, interfaceLocked;
    int          err_total = 0, n_compared = 0;
    acd_spi_decoder #(.RAW_W(20)) i_acd_spi_decoder (.clock(clock),
        .nrst(nrst), .csN(csN), .sclk(sclk), .din(din), .dout(dout),
        .doutOe(), .rawCh0(rawCh0), .rawCh1(rawCh1), .rawCh2(rawCh2),
        .rawCh3(rawCh3), .sampleStrobe(sampleStrobe),
        .dataReadyN(dataReadyN), .standbyMode(standbyMode),
        .interfaceLocked(interfaceLocked));
    acd_host i_acd_host (.clock(clock), .csN(csN), .sclk(sclk), .din(din),
        .dout(dout));
    initial
    begin
        clock = 0;
        forever #10 clock = ~clock;
    end
    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, e);
        n_compared++;
        if (g !== e)
        begin
            $display("Error at %0t got %h expected %h", $time, g, e);
            err_total++;
        end
    endtask
    // command frame, then a no-op frame that carries its answer
    task automatic xfer(input logic [15:0] c, d, e, input int nw);
        i_acd_host.frame(c, d, nw);
        i_acd_host.frame(16'h0, 16'h0, 6);
        chk(i_acd_host.got[0], e);
    endtask
    task automatic pulse();
        sampleStrobe = 1;
        @(posedge clock);
        #1 sampleStrobe = 0;
        @(posedge clock);
        #1;
    endtask
    task automatic t_clip();
        {rawCh0, rawCh1} = {20'h7_FFFF, 20'hF_FFFF};
        {rawCh2, rawCh3} = {20'h8_0000, 20'h0_0001};
        pulse();
        chk({15'h0, dataReadyN}, 16'h0);
        i_acd_host.frame(16'h0, 16'h0, 6);
        chk(i_acd_host.got[1], 16'h7FFF);
        chk(i_acd_host.got[2], 16'hFFFF);
        chk(i_acd_host.got[3], 16'h8000);
        chk(i_acd_host.got[4], 16'h0001);
    endtask
    task automatic t_modes();
        xfer(16'h0022, 16'h0, 16'h0022, 6);
        pulse();
        chk({15'h0, dataReadyN}, 16'h0001);
        xfer(16'h0022, 16'h0, 16'h0022, 6);
        xfer(16'h0033, 16'h0, 16'h0033, 6);
        chk({15'h0, standbyMode}, 16'h0);
    endtask
    task automatic t_lock();
        xfer(16'h0555, 16'h0, 16'h0555, 6);
        xfer(16'h0022, 16'h0, 16'h8500, 6);
        chk({15'h0, standbyMode}, 16'h0);
        xfer(16'hA100, 16'h0, 16'h0510, 6);
        xfer(16'h0666, 16'h0, 16'h0666, 6);
        chk({15'h0, interfaceLocked}, 16'h0);
    endtask
    task automatic t_regs();
        xfer(16'h6180, 16'h0F0F, 16'h4180, 6);
        xfer(16'hA180, 16'h0, 16'h0F0F, 6);
        xfer(16'h6600, 16'h1234, 16'h467F, 6);
        xfer(16'hA600, 16'h0, 16'h8000, 6);
        xfer(16'hA101, 16'h0, 16'hE101, 6);
        chk(i_acd_host.got[1], 16'h0510);
        chk(i_acd_host.got[2], 16'h0F0F);
        xfer(16'h0011, 16'h0, 16'h0011, 2);
        xfer(16'h0011, 16'h0, 16'hFF54, 6);
        xfer(16'hA180, 16'h0, 16'h0F8E, 6);
    endtask
    // rx crc on, zero crc words: only the write may run
    task automatic t_crc();
        i_acd_host.frame(16'h6100, 16'h1510, 6);
        i_acd_host.frame(16'h0022, 16'h0, 6);
        chk(i_acd_host.got[0], 16'h4100);
        chk({15'h0, standbyMode}, 16'h0);
        i_acd_host.frame(16'h6100, 16'h0510, 6);
        chk(i_acd_host.got[0], 16'h1500);
        xfer(16'h0, 16'h0, 16'h0500, 6);
        chk(i_acd_host.padHi[15:0], 16'h0);
    endtask
    initial
    begin
        {nrst, sampleStrobe} = 2'b00;
        {rawCh0, rawCh1, rawCh2, rawCh3} = 80'h0;
        repeat (2) @(posedge clock);
        #1 nrst = 1;
        xfer(16'h0, 16'h0, 16'h0500, 6);
        xfer(16'h1234, 16'h0, 16'h0500, 6);
        t_clip();
        t_modes();
        t_lock();
        t_regs();
        t_crc();
        stop_test();
    end
    // hang guard, about 1.6 times the expected run
    initial
    begin
        #1500us;
        err_total++;
        stop_test();
    end
endmodule // adc_spi_command_decoder_tb
